/* logic/dsrb_bp_encoder.sv */
/*
  Lowest-number-first encoder for breakpoint and watchpoint hits.
  Assumes hits are the simultaneous triggers of one debugger entry.
*/
module dsrb_bp_encoder (
  input  wire logic [dsrb_pkg::BP_N-1:0] hits,
  output logic [dsrb_pkg::BP_W-1:0]      bp_num
);

  // lowest set bit wins
  assign bp_num = hits[0] ? 2'h0 :
                  hits[1] ? 2'h1 :
                  hits[2] ? 2'h2 :
                  hits[3] ? 2'h3 : 2'h0;

endmodule : dsrb_bp_encoder

/* logic/dsrb_pkg.sv */
/*
  Package for the debug status register bank: register offsets, field positions,
  write masks, cause codes and the debugger-entry carrier struct.
  Assumes a status-register access port with 8-bit word offsets on core_clk.
*/
package dsrb_pkg;

  // register offsets as seen by the status-register access instructions
  localparam logic [7:0] OFS_RING_CELL   = 8'h09;
  localparam logic [7:0] OFS_RING_WIRE   = 8'h0A;
  localparam logic [7:0] OFS_MEM_SIZE    = 8'h0C;
  localparam logic [7:0] OFS_DBG_STATUS  = 8'h10;
  localparam logic [7:0] OFS_DBG_PC      = 8'h11;
  localparam logic [7:0] OFS_DBG_STACK   = 8'h12;
  localparam logic [7:0] OFS_RD_THREAD   = 8'h13;
  localparam logic [7:0] OFS_RD_REG      = 8'h14;
  localparam logic [7:0] OFS_DBG_CAUSE   = 8'h15;
  localparam logic [7:0] OFS_DEBUG_ENTRY_DATA    = 8'h16;

  // ring counters and memory size
  localparam int          RING_W         = 16;
  localparam logic [31:0] MEM_SIZE_BYTES = 32'h0002_0000;
  localparam logic [31:0] MEM_SIZE_MASK  = 32'hFFFF_FFFC;

  // saved status word bit positions
  localparam int SSR_EVENT_EN   = 0;
  localparam int SSR_IRQ_EN     = 1;
  localparam int SSR_EVT_SETUP  = 2;
  localparam int SSR_IN_HANDLER = 3;
  localparam int SSR_KERNEL     = 4;
  localparam int SSR_PAUSED     = 6;
  localparam int SSR_FAST       = 7;
  localparam int SSR_ISSUE_MODE = 8;
  localparam int SSR_ISSUE_KENT = 9;
  localparam int SSR_ASID       = 10;
  localparam logic [31:0] SSR_IMPL_MASK  = 32'h0000_07DF;
  localparam logic [31:0] SSR_WRITE_MASK = 32'h0000_06DF;

  // operand and cause field layouts
  localparam int THREAD_W = 8;
  localparam int REGIDX_W = 5;
  localparam int BP_W     = 2;
  localparam int BP_N     = 4;
  localparam int CAUSE_LO = 0;
  localparam int TNUM_LO  = 8;
  localparam int BPNUM_LO = 16;
  localparam logic [31:0] CAUSE_WRITE_MASK = 32'h0003_FF07;
  localparam logic [31:0] CAUSE_RESET      = 32'h0000_0000;

  typedef enum logic [2:0] {
    DSRB_CAUSE_NONE  = 3'h0,
    DSRB_CAUSE_HOST  = 3'h1,
    DSRB_CAUSE_CALL  = 3'h2,
    DSRB_CAUSE_IBRK  = 3'h3,
    DSRB_CAUSE_DWTCH = 3'h4,
    DSRB_CAUSE_RWTCH = 3'h5
  } dsrb_cause_t;

  // everything the core hands over at debugger entry
  typedef struct packed {
    dsrb_cause_t          cause;
    logic [THREAD_W-1:0]  thread;
    logic [BP_N-1:0]      bp_hits;
    logic [31:0]          status;
    logic [31:0]          pc;
    logic [31:0]          sp;
    logic [31:0]          mem_addr;
    logic [31:0]          resource_id;
  } dsrb_entry_t;

endpackage : dsrb_pkg

/* logic/dsrb_ring_counter.sv */
/*
  One ring-oscillator event counter, 16 bits, wrapping.
  Assumes tick is a one-cycle pulse synchronous to core_clk; only por_clr clears it.
*/
module dsrb_ring_counter (
  input  wire logic                      core_clk,
  input  wire logic                      por_clr,
  input  wire logic                      tick,
  output logic [dsrb_pkg::RING_W-1:0]    count
);

  logic [dsrb_pkg::RING_W-1:0] count_reg;
  logic [dsrb_pkg::RING_W-1:0] count_next;

  // system reset is not an input here, so counts survive it
  assign count_next = por_clr ? '0 : (tick ? count_reg + 16'h0001 : count_reg);
  assign count      = count_reg;

  always_ff @(posedge core_clk) begin
    count_reg <= count_next;
  end

  ring_step_a: assert property (@(posedge core_clk) disable iff (por_clr)
    tick |=> count_reg == $past(count_reg) + 16'h0001) else $error("ring counter missed a tick");

endmodule : dsrb_ring_counter

/* logic/dsrb_top.sv */
/*
  Debug status register bank of one processor tile: ring counters, memory size,
  and the debugger-entry capture registers with their read operands.
  Assumes status-register reads and writes arrive as one-cycle strobes on core_clk,
  and that debugger entry is a one-cycle strobe carrying a dsrb_entry_t.
*/
// Contract
// - ring counts survive system reset
// - cell count in bits 15:0, read-only
// - wire count in bits 15:0, read-only
// - memory size bytes in 31:2, read-only
// - capture status word at debugger entry
// - kernel bit4, handler bit3, setup bit2
// - irq enable bit1, event enable bit0
// - fast issue bit7, paused waiting bit6
// - issue mode bit8 read-only, bits 9,10
// - capture program counter, full 32-bit RW
// - capture stack pointer, full 32-bit RW
// - thread operand 8 bits selects source
// - register operand 5 bits selects register
// - cause codes one to five
// - breakpoint number, zero for host/call
// - lowest simultaneous breakpoint reported
// - causing thread, zero for host
// - data watchpoint loads effective address
// - resource watchpoint loads resource id
module dsrb_top (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  por_clr,
  input  wire logic                  osc_cell_tick,
  input  wire logic                  osc_wire_tick,
  input  wire logic                  ps_rd,
  input  wire logic                  ps_wr,
  input  wire logic [7:0]            ps_addr,
  input  wire logic [31:0]           ps_wdata,
  output logic [31:0]                ps_rdata,
  output logic                       ps_rvalid,
  input  wire logic                  entry_strobe,
  input  wire dsrb_pkg::dsrb_entry_t entry_info,
  output logic [7:0]                 read_thread_id,
  output logic [4:0]                 read_register_index,
  output logic [31:0]                resume_status,
  output logic [31:0]                resume_pc,
  output logic [31:0]                resume_sp
);

  logic [15:0] cell_count;
  logic [15:0] wire_count;
  logic [1:0]  entry_bp_num;

  logic [31:0] status_reg;
  logic [31:0] status_next;
  logic [31:0] pc_reg;
  logic [31:0] pc_next;
  logic [31:0] sp_reg;
  logic [31:0] sp_next;
  logic [7:0]  thread_sel_reg;
  logic [7:0]  thread_sel_next;
  logic [4:0]  reg_sel_reg;
  logic [4:0]  reg_sel_next;
  logic [31:0] cause_reg;
  logic [31:0] cause_next;
  logic [31:0] data_reg;
  logic [31:0] data_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rvalid_reg;

  // counters sit outside the system reset
  dsrb_ring_counter u_ring_cell (
    .core_clk (core_clk),
    .por_clr  (por_clr),
    .tick     (osc_cell_tick),
    .count    (cell_count)
  );

  dsrb_ring_counter u_ring_wire (
    .core_clk (core_clk),
    .por_clr  (por_clr),
    .tick     (osc_wire_tick),
    .count    (wire_count)
  );

  dsrb_bp_encoder u_bp_enc (
    .hits   (entry_info.bp_hits),
    .bp_num (entry_bp_num)
  );

  // write strobes per register
  wire wr_status = ps_wr && (ps_addr == dsrb_pkg::OFS_DBG_STATUS);
  wire wr_pc     = ps_wr && (ps_addr == dsrb_pkg::OFS_DBG_PC);
  wire wr_sp     = ps_wr && (ps_addr == dsrb_pkg::OFS_DBG_STACK);
  wire wr_thread = ps_wr && (ps_addr == dsrb_pkg::OFS_RD_THREAD);
  wire wr_regsel = ps_wr && (ps_addr == dsrb_pkg::OFS_RD_REG);
  wire wr_cause  = ps_wr && (ps_addr == dsrb_pkg::OFS_DBG_CAUSE);
  wire wr_data   = ps_wr && (ps_addr == dsrb_pkg::OFS_DEBUG_ENTRY_DATA);

  // entry classification
  wire is_host  = entry_info.cause == dsrb_pkg::DSRB_CAUSE_HOST;
  wire is_call  = entry_info.cause == dsrb_pkg::DSRB_CAUSE_CALL;
  wire is_dwtch = entry_info.cause == dsrb_pkg::DSRB_CAUSE_DWTCH;
  wire is_rwtch = entry_info.cause == dsrb_pkg::DSRB_CAUSE_RWTCH;

  wire [7:0]  entry_thread = is_host ? 8'h00 : entry_info.thread;
  wire [1:0]  entry_bp     = (is_host || is_call) ? 2'h0 : entry_bp_num;
  wire [31:0] entry_cause  = {14'h0000, entry_bp, entry_thread, 5'h00, entry_info.cause};

  // status capture keeps the implemented bits, bit 8 only from the core
  wire [31:0] entry_status = entry_info.status & dsrb_pkg::SSR_IMPL_MASK;
  wire [31:0] sw_status    = (ps_wdata & dsrb_pkg::SSR_WRITE_MASK) |
                             (status_reg & ~dsrb_pkg::SSR_WRITE_MASK);

  // entry wins over a software write in the same cycle
  assign status_next = entry_strobe ? entry_status : (wr_status ? sw_status : status_reg);
  assign pc_next     = entry_strobe ? entry_info.pc : (wr_pc ? ps_wdata : pc_reg);
  assign sp_next     = entry_strobe ? entry_info.sp : (wr_sp ? ps_wdata : sp_reg);
  assign thread_sel_next = wr_thread ? ps_wdata[7:0] : thread_sel_reg;
  assign reg_sel_next    = wr_regsel ? ps_wdata[4:0] : reg_sel_reg;
  assign cause_next  = entry_strobe ? entry_cause :
                       (wr_cause ? (ps_wdata & dsrb_pkg::CAUSE_WRITE_MASK) : cause_reg);
  // other causes leave the data word as it was unless software writes it in the same cycle
  assign data_next   = (entry_strobe && is_dwtch) ? entry_info.mem_addr :
                       (entry_strobe && is_rwtch) ? entry_info.resource_id :
                       (wr_data ? ps_wdata : data_reg);

  // read decode; reserved bits and unmapped offsets read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (ps_addr == dsrb_pkg::OFS_RING_CELL) begin
      rdata_next = {16'h0000, cell_count};
    end else if (ps_addr == dsrb_pkg::OFS_RING_WIRE) begin
      rdata_next = {16'h0000, wire_count};
    end else if (ps_addr == dsrb_pkg::OFS_MEM_SIZE) begin
      rdata_next = dsrb_pkg::MEM_SIZE_BYTES & dsrb_pkg::MEM_SIZE_MASK;
    end else if (ps_addr == dsrb_pkg::OFS_DBG_STATUS) begin
      rdata_next = status_reg;
    end else if (ps_addr == dsrb_pkg::OFS_DBG_PC) begin
      rdata_next = pc_reg;
    end else if (ps_addr == dsrb_pkg::OFS_DBG_STACK) begin
      rdata_next = sp_reg;
    end else if (ps_addr == dsrb_pkg::OFS_RD_THREAD) begin
      rdata_next = {24'h000000, thread_sel_reg};
    end else if (ps_addr == dsrb_pkg::OFS_RD_REG) begin
      rdata_next = {27'h0000000, reg_sel_reg};
    end else if (ps_addr == dsrb_pkg::OFS_DBG_CAUSE) begin
      rdata_next = cause_reg;
    end else if (ps_addr == dsrb_pkg::OFS_DEBUG_ENTRY_DATA) begin
      rdata_next = data_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg     <= 32'h0000_0000;
      pc_reg         <= 32'h0000_0000;
      sp_reg         <= 32'h0000_0000;
      thread_sel_reg <= 8'h00;
      reg_sel_reg    <= 5'h00;
      cause_reg      <= dsrb_pkg::CAUSE_RESET;
      data_reg       <= 32'h0000_0000;
    end else begin
      status_reg     <= status_next;
      pc_reg         <= pc_next;
      sp_reg         <= sp_next;
      thread_sel_reg <= thread_sel_next;
      reg_sel_reg    <= reg_sel_next;
      cause_reg      <= cause_next;
      data_reg       <= data_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg  <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= ps_rd ? rdata_next : rdata_reg;
      rvalid_reg <= ps_rd;
    end
  end

  assign ps_rdata            = rdata_reg;
  assign ps_rvalid           = rvalid_reg;
  assign read_thread_id      = thread_sel_reg;
  assign read_register_index = reg_sel_reg;
  assign resume_status       = status_reg;
  assign resume_pc           = pc_reg;
  assign resume_sp           = sp_reg;

  // checks
  sequence s_entry;
    entry_strobe;
  endsequence

  sequence s_host_entry;
    entry_strobe && is_host;
  endsequence

  sequence s_read_cell;
    ps_rd && ps_addr == dsrb_pkg::OFS_RING_CELL;
  endsequence

  sequence s_read_mem;
    ps_rd && ps_addr == dsrb_pkg::OFS_MEM_SIZE;
  endsequence

  sequence s_read_wire;
    ps_rd && ps_addr == dsrb_pkg::OFS_RING_WIRE;
  endsequence

  sequence s_read_thread;
    ps_rd && ps_addr == dsrb_pkg::OFS_RD_THREAD;
  endsequence

  sequence s_read_regsel;
    ps_rd && ps_addr == dsrb_pkg::OFS_RD_REG;
  endsequence

  status_capture_a: assert property (@(posedge core_clk) disable iff (rst)
    s_entry |=> status_reg == ($past(entry_info.status) & 32'h0000_07DF))
    else $error("status word not captured");

  issue_mode_ro_a: assert property (@(posedge core_clk) disable iff (rst)
    (wr_status && !entry_strobe) |=> status_reg[8] == $past(status_reg[8]))
    else $error("issue mode bit changed by write");

  pc_capture_a: assert property (@(posedge core_clk) disable iff (rst)
    s_entry |=> pc_reg == $past(entry_info.pc) && sp_reg == $past(entry_info.sp))
    else $error("pc or sp not captured");

  host_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    s_host_entry |=> cause_reg[17:8] == 10'h000 && cause_reg[2:0] == 3'h1)
    else $error("host entry fields wrong");

  lowest_bp_a: assert property (@(posedge core_clk) disable iff (rst)
    (entry_strobe && entry_info.cause == dsrb_pkg::DSRB_CAUSE_IBRK && entry_info.bp_hits[1:0] == 2'b11)
    |=> cause_reg[17:16] == 2'h0)
    else $error("lowest breakpoint not reported");

  call_bp_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    (entry_strobe && is_call) |=> cause_reg[17:16] == 2'h0 && cause_reg[15:8] == $past(entry_info.thread))
    else $error("call entry fields wrong");

  watch_data_a: assert property (@(posedge core_clk) disable iff (rst)
    (entry_strobe && is_dwtch) |=> data_reg == $past(entry_info.mem_addr))
    else $error("watch address not loaded");

  resource_data_a: assert property (@(posedge core_clk) disable iff (rst)
    (entry_strobe && is_rwtch) |=> data_reg == $past(entry_info.resource_id))
    else $error("resource id not loaded");

  cell_read_a: assert property (@(posedge core_clk) disable iff (rst)
    s_read_cell |=> ps_rvalid && ps_rdata[31:16] == 16'h0000 && ps_rdata[15:0] == $past(cell_count))
    else $error("cell count read wrong");

  mem_read_a: assert property (@(posedge core_clk) disable iff (rst)
    s_read_mem |=> ps_rdata[1:0] == 2'h0 && ps_rdata[31:2] == dsrb_pkg::MEM_SIZE_BYTES[31:2])
    else $error("memory size read wrong");

  operand_mask_a: assert property (@(posedge core_clk) disable iff (rst)
    (ps_wr && ps_addr == dsrb_pkg::OFS_RD_REG) |=> read_register_index == $past(ps_wdata[4:0]))
    else $error("register operand not written");

  cause_reserved_a: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |-> cause_reg[31:18] == 14'h0000 && cause_reg[7:3] == 5'h00)
    else $error("reserved cause bits set");

  wire_read_a: assert property (@(posedge core_clk) disable iff (rst)
    s_read_wire |=> ps_rvalid && ps_rdata == {16'h0000, $past(wire_count)})
    else $error("wire count read wrong");

  status_reserved_a: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |-> status_reg[31:11] == 21'h00_0000 && status_reg[5] == 1'b0)
    else $error("reserved status bits set");

  kernel_bits_a: assert property (@(posedge core_clk) disable iff (rst)
    s_entry |=> status_reg[4:2] == $past(entry_info.status[4:2]))
    else $error("kernel handler setup bits not captured");

  enable_bits_a: assert property (@(posedge core_clk) disable iff (rst)
    s_entry |=> status_reg[1:0] == $past(entry_info.status[1:0]))
    else $error("enable bits not captured");

  fast_pause_a: assert property (@(posedge core_clk) disable iff (rst)
    s_entry |=> status_reg[7:6] == $past(entry_info.status[7:6]))
    else $error("fast or paused bit not captured");

  issue_entry_a: assert property (@(posedge core_clk) disable iff (rst)
    s_entry |=> status_reg[10:8] == $past(entry_info.status[10:8]))
    else $error("issue mode or space id not captured");

  stack_capture_a: assert property (@(posedge core_clk) disable iff (rst)
    s_entry |=> sp_reg == $past(entry_info.sp))
    else $error("stack pointer not captured");

  thread_operand_a: assert property (@(posedge core_clk) disable iff (rst)
    (ps_wr && ps_addr == dsrb_pkg::OFS_RD_THREAD) |=> read_thread_id == $past(ps_wdata[7:0]))
    else $error("thread operand not written");

  cause_code_a: assert property (@(posedge core_clk) disable iff (rst)
    s_entry |=> cause_reg[2:0] == $past(entry_info.cause))
    else $error("cause code not stored");

  cause_thread_a: assert property (@(posedge core_clk) disable iff (rst)
    (entry_strobe && !is_host) |=> cause_reg[15:8] == $past(entry_info.thread))
    else $error("causing thread not stored");

  second_bp_a: assert property (@(posedge core_clk) disable iff (rst)
    (entry_strobe && !is_host && !is_call && entry_info.bp_hits[1:0] == 2'b10) |=> cause_reg[17:16] == 2'h1)
    else $error("breakpoint one not reported");

  data_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    (entry_strobe && !is_dwtch && !is_rwtch && !wr_data) |=> data_reg == $past(data_reg))
    else $error("data word changed without watchpoint");

  thread_read_a: assert property (@(posedge core_clk) disable iff (rst)
    s_read_thread |=> ps_rdata[31:8] == 24'h00_0000 && ps_rdata[7:0] == $past(read_thread_id))
    else $error("thread operand read wrong");

  regsel_read_a: assert property (@(posedge core_clk) disable iff (rst)
    s_read_regsel |=> ps_rdata[31:5] == 27'h000_0000 && ps_rdata[4:0] == $past(read_register_index))
    else $error("register operand read wrong");

  pc_write_a: assert property (@(posedge core_clk) disable iff (rst)
    (wr_pc && !entry_strobe) |=> pc_reg == $past(ps_wdata))
    else $error("pc write lost");

  stack_write_a: assert property (@(posedge core_clk) disable iff (rst)
    (wr_sp && !entry_strobe) |=> sp_reg == $past(ps_wdata))
    else $error("stack write lost");

  data_write_a: assert property (@(posedge core_clk) disable iff (rst)
    (wr_data && !entry_strobe) |=> data_reg == $past(ps_wdata))
    else $error("data write lost");

  status_write_a: assert property (@(posedge core_clk) disable iff (rst)
    (wr_status && !entry_strobe) |=>
    (status_reg & dsrb_pkg::SSR_WRITE_MASK) == ($past(ps_wdata) & dsrb_pkg::SSR_WRITE_MASK))
    else $error("status write lost");

endmodule : dsrb_top

/* testbench/dsrb_bench.sv */
/*
  Self-checking bench for the debug status register bank with a reference register image.
  Assumes dsrb_sw_model drives the register port and the bench drives entry and ticks.
*/
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module dsrb_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, por_clr, osc_cell_tick, osc_wire_tick, ps_rd, ps_wr, ps_rvalid, entry_strobe;
  logic [7:0]  ps_addr, read_thread_id;
  logic [4:0]  read_register_index;
  logic [31:0] ps_wdata, ps_rdata, resume_status, resume_pc, resume_sp, d;
  dsrb_pkg::dsrb_entry_t entry_info;
  logic [31:0] m [0:31];
  logic [15:0] lf = 16'h482A;
  int bad_count, checked, cycles, cell_n, wire_n;

  dsrb_top i_dsrb_top (.core_clk(core_clk), .rst(rst), .por_clr(por_clr), .osc_cell_tick(osc_cell_tick),
    .osc_wire_tick(osc_wire_tick), .ps_rd(ps_rd), .ps_wr(ps_wr), .ps_addr(ps_addr), .ps_wdata(ps_wdata),
    .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid), .entry_strobe(entry_strobe), .entry_info(entry_info),
    .read_thread_id(read_thread_id), .read_register_index(read_register_index),
    .resume_status(resume_status), .resume_pc(resume_pc), .resume_sp(resume_sp));
  dsrb_sw_model i_dsrb_sw_model (.core_clk(core_clk), .ps_rd(ps_rd), .ps_wr(ps_wr), .ps_addr(ps_addr),
    .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid));

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd

  function automatic logic [31:0] wmask(input logic [7:0] a);
    case (a)
      dsrb_pkg::OFS_DBG_STATUS: return dsrb_pkg::SSR_WRITE_MASK;
      dsrb_pkg::OFS_DBG_PC, dsrb_pkg::OFS_DBG_STACK, dsrb_pkg::OFS_DEBUG_ENTRY_DATA: return 32'hFFFF_FFFF;
      dsrb_pkg::OFS_RD_THREAD: return 32'h0000_00FF;
      dsrb_pkg::OFS_RD_REG: return 32'h0000_001F;
      dsrb_pkg::OFS_DBG_CAUSE: return dsrb_pkg::CAUSE_WRITE_MASK;
      default: return 32'h0000_0000;
    endcase
  endfunction : wmask

  task automatic chk(input logic [7:0] a);
    logic [31:0] v;
    i_dsrb_sw_model.rd(a, v);
    `CHK("register", m[a], v)
  endtask : chk

  task automatic entry(input int c);
    dsrb_pkg::dsrb_entry_t e;
    logic [1:0] bp;
    logic [7:0] th;
    logic [207:0] r;
    r = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    e = r[$bits(dsrb_pkg::dsrb_entry_t)-1:0];
    e.cause = dsrb_pkg::dsrb_cause_t'(c);
    if (c == 3) e.bp_hits[1:0] = 2'b11;
    bp = 2'h0;
    for (int i = 3; i >= 0; i--) if (e.bp_hits[i]) bp = i[1:0];
    if (c == 1 || c == 2) bp = 2'h0;
    th = (c == 1) ? 8'h00 : e.thread;
    m[dsrb_pkg::OFS_DBG_STATUS] = e.status & dsrb_pkg::SSR_IMPL_MASK;
    m[dsrb_pkg::OFS_DBG_PC] = e.pc;
    m[dsrb_pkg::OFS_DBG_STACK] = e.sp;
    m[dsrb_pkg::OFS_DBG_CAUSE] = {14'h0000, bp, th, 5'h00, c[2:0]};
    if (c == 4) m[dsrb_pkg::OFS_DEBUG_ENTRY_DATA] = e.mem_addr;
    if (c == 5) m[dsrb_pkg::OFS_DEBUG_ENTRY_DATA] = e.resource_id;
    @(posedge core_clk);
    entry_strobe <= 1'b1;
    entry_info <= e;
    @(posedge core_clk);
    entry_strobe <= 1'b0;
    entry_info <= ~e;
    chk(dsrb_pkg::OFS_DBG_STATUS);
    chk(dsrb_pkg::OFS_DBG_PC);
    chk(dsrb_pkg::OFS_DBG_STACK);
    chk(dsrb_pkg::OFS_DBG_CAUSE);
    chk(dsrb_pkg::OFS_DEBUG_ENTRY_DATA);
    `CHK("resume_status", m[dsrb_pkg::OFS_DBG_STATUS], resume_status)
  endtask : entry

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    por_clr = 1'b1;
    osc_cell_tick = 1'b0;
    osc_wire_tick = 1'b0;
    entry_strobe = 1'b0;
    entry_info = '0;
    for (int k = 0; k < 32; k++) m[k] = 32'h0000_0000;
    m[dsrb_pkg::OFS_MEM_SIZE] = dsrb_pkg::MEM_SIZE_BYTES & dsrb_pkg::MEM_SIZE_MASK;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    por_clr <= 1'b0;
    repeat (40) begin
      @(posedge core_clk);
      d[15:0] = rnd();
      osc_cell_tick <= d[0];
      osc_wire_tick <= d[5];
      cell_n += d[0];
      wire_n += d[5];
    end
    @(posedge core_clk);
    osc_cell_tick <= 1'b0;
    osc_wire_tick <= 1'b0;
    repeat (10) @(posedge core_clk);
    m[dsrb_pkg::OFS_RING_CELL] = {16'h0000, cell_n[15:0]};
    m[dsrb_pkg::OFS_RING_WIRE] = {16'h0000, wire_n[15:0]};
    chk(dsrb_pkg::OFS_RING_CELL);
    chk(dsrb_pkg::OFS_RING_WIRE);
    chk(dsrb_pkg::OFS_MEM_SIZE);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    chk(dsrb_pkg::OFS_RING_CELL);
    chk(dsrb_pkg::OFS_RING_WIRE);
    for (int a = 8'h09; a <= 8'h16; a++) begin
      d = {rnd(), rnd()};
      i_dsrb_sw_model.wr(a[7:0], d);
      m[a] = (m[a] & ~wmask(a[7:0])) | (d & wmask(a[7:0]));
      chk(a[7:0]);
    end
    `CHK("read_thread_id", m[dsrb_pkg::OFS_RD_THREAD][7:0], read_thread_id)
    `CHK("read_register_index", m[dsrb_pkg::OFS_RD_REG][4:0], read_register_index)
    `CHK("resume_status", m[dsrb_pkg::OFS_DBG_STATUS], resume_status)
    `CHK("resume_pc", m[dsrb_pkg::OFS_DBG_PC], resume_pc)
    `CHK("resume_sp", m[dsrb_pkg::OFS_DBG_STACK], resume_sp)
    for (int c = 0; c <= 5; c++) repeat (3) begin
      entry(c);
      d = {rnd(), rnd()};
      i_dsrb_sw_model.wr(dsrb_pkg::OFS_DBG_STATUS, d);
      m[dsrb_pkg::OFS_DBG_STATUS] = (m[dsrb_pkg::OFS_DBG_STATUS] & ~dsrb_pkg::SSR_WRITE_MASK) |
                                    (d & dsrb_pkg::SSR_WRITE_MASK);
      chk(dsrb_pkg::OFS_DBG_STATUS);
    end
    give_verdict();
  end
endmodule : dsrb_bench

/* testbench/dsrb_sw_model.sv */
/*
  Debug software model: issues status-register reads and writes as one-cycle strobes.
  Assumes the bank answers a read with ps_rvalid exactly one cycle after ps_rd.
*/
module dsrb_sw_model (
  input  wire logic        core_clk,
  output logic             ps_rd,
  output logic             ps_wr,
  output logic [7:0]       ps_addr,
  output logic [31:0]      ps_wdata,
  input  wire logic [31:0] ps_rdata,
  input  wire logic        ps_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ps_rd = 1'b0;
    ps_wr = 1'b0;
    ps_addr = 8'h00;
    ps_wdata = 32'h0000_0000;
  end

  // operand writes select thread and register for the read instruction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    ps_wr <= 1'b1;
    ps_addr <= a;
    ps_wdata <= d;
    @(posedge core_clk);
    ps_wr <= 1'b0;
    ps_addr <= ~a;
    ps_wdata <= ~d;
  endtask : wr

  // caller stops the oscillators ten cycles before reading a counter
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    ps_rd <= 1'b1;
    ps_addr <= a;
    @(posedge core_clk);
    ps_rd <= 1'b0;
    ps_addr <= ~a;
    #1;
    d = (ps_rvalid === 1'b1) ? ps_rdata : 32'hXXXX_XXXX;
  endtask : rd
endmodule : dsrb_sw_model
